// File: pkg/tse_pkg.sv
// Purpose: Shared constants and types for the trap syndrome encoder.
// Assumes: One core clock; trap requests come from logic on that clock.
// Notes:   Class codes for illegal state and alignment faults are plain defaults.
package tse_pkg;

  // ------------------------------------------------------------------
  // Exception class codes
  // ------------------------------------------------------------------
  localparam logic [5:0] EC_UNKNOWN   = 6'h00;
  localparam logic [5:0] EC_COPROC_LS = 6'h06;
  localparam logic [5:0] EC_FP_SIMD   = 6'h07;
  localparam logic [5:0] EC_VECTOR    = 6'h19;
  localparam logic [5:0] EC_ILLEGAL   = 6'h0e;
  localparam logic [5:0] EC_PC_ALIGN  = 6'h22;
  localparam logic [5:0] EC_SP_ALIGN  = 6'h26;

  // ------------------------------------------------------------------
  // Field positions and values
  // ------------------------------------------------------------------
  localparam int         POS_CV      = 24;
  localparam int         POS_CONDITION_CODE_FIELD    = 20;
  localparam int         POS_IMM8    = 12;
  localparam int         POS_OFFSET  = 4;
  localparam int         POS_AM      = 1;
  localparam int         POS_DIR     = 0;
  localparam logic [3:0] CONDITION_CODE_FIELD_ALWAYS = 4'he;

  // ------------------------------------------------------------------
  // Register offsets, fields and reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] REG_SYND      = 8'h00;
  localparam logic [7:0] REG_CTRL      = 8'h04;
  localparam logic [7:0] REG_STAT      = 8'h08;
  localparam int         POS_CLASS     = 26;
  localparam int         CTRL_CMP_CV   = 0;
  localparam int         CTRL_PASS_AL  = 1;
  localparam int         STAT_CAPT     = 0;
  localparam int         STAT_BADFORM  = 1;
  localparam int         POS_COUNT     = 8;
  localparam logic [1:0] CTRL_RESET    = 2'h1;
  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // Kinds of trap that the core reports.
  typedef enum logic [2:0] {
    TK_COPROC_LS,
    TK_FP_SIMD,
    TK_VECTOR,
    TK_ILLEGAL,
    TK_PC_ALIGN,
    TK_SP_ALIGN
  } tse_kind_t;

  // Trap request from the core, valid for one cycle.
  typedef struct packed {
    logic       valid;
    tse_kind_t  kind;
    logic       state64;
    logic       compact;
    logic       conditional;
    logic       knownPass;
    logic [3:0] instrCond;
    logic [7:0] imm8;
    logic       offsetAdd;
    logic       literalForm;
    logic       preIndex;
    logic       writeback;
    logic       isLoad;
  } tse_trap_t;

  // Reported syndrome.
  typedef struct packed {
    logic [5:0]  excClass;
    logic [24:0] payload;
  } tse_synd_t;

  // Whole state of the encoder.
  typedef struct packed {
    tse_synd_t   synd;
    logic        syndValid;
    logic        captured;
    logic        badForm;
    logic [7:0]  count;
    logic [1:0]  ctrl;
    logic        awReady;
    logic        wReady;
    logic        awHeld;
    logic        wHeld;
    logic [7:0]  awAddr;
    logic [31:0] wData;
    logic [3:0]  wStrb;
    logic        bValid;
    logic [1:0]  bResp;
    logic        arReady;
    logic        rValid;
    logic [31:0] rData;
    logic [1:0]  rResp;
  } tse_state_t;

endpackage

// File: design/tse_trap_syndrome_encoder.sv
// Purpose: Builds the exception class and syndrome payload for trapped
//          coprocessor load/store, floating-point, vector, illegal state
//          and alignment exceptions, with an AXI4-Lite register view.
// Assumes: Trap requests and feature straps come from logic on mclk.
// Notes:   The register-number field of the load/store syndrome reads zero.
//
// Notes on behaviour
// RL1 - Offset flag is 1 when the offset is added, 0 when subtracted.
// RL2 - Immediate forms encode unindexed 000, post 001, offset 010, pre 011.
// RL3 - Mode 100 never for stores or compact loads; 110 never for stores.
// RL4 - Modes 101 and 111 are reserved and never produced.
// RL5 - High mode bit shows immediate form (0) or literal form (1).
// RL6 - Low mode bits copy the pre-index and writeback bits.
// RL7 - Direction bit is 0 for a store and 1 for a load.
// RL8 - Coprocessor load/store traps use class 000110.
// RL9 - Floating-point trap covers vector, SIMD, FP and matrix accesses.
// RL10 - With no vector and no FP support the class is 000000.
// RL11 - Condition-valid is 1 for 64-bit state and fixed-width; low 20 zero.
// RL12 - From 64-bit state the condition field holds 1110.
// RL13 - Fixed-width: own condition if conditional, else 1110.
// RL14 - A known-passing conditional may report 1110 or its condition.
// RL15 - Compact: either clear valid flag, or set it with the condition.
// RL16 - Floating-point traps use class 000111.
// RL17 - Vector trap payload is all zero.
// RL18 - With no vector support the vector trap reports class 000000.
// RL19 - Vector traps use class 011001.
// RL20 - Illegal state and PC/SP alignment faults give a zero payload.
// RL21 - Fields need no particular value after a warm reset.
// RL22 - Register-number field is valid only for the immediate form; the code leaves it zero for every form.
// RL23 - Syndrome is captured at entry and held until the next trap.
`timescale 1ns/100ps

module tse_trap_syndrome_encoder
  import tse_pkg::*;
(
  input  wire logic               mclk,
  input  wire logic               rst,
  input  wire tse_pkg::tse_trap_t trap,
  input  wire logic               fpPresent,
  input  wire logic               vecPresent,
  output tse_pkg::tse_synd_t      synd,
  output logic                    syndValid,
  input  wire logic [7:0]         awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [7:0]         araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready
);

  import tse_pkg::*;

  tse_state_t st;
  tse_state_t next_st;

  // ------------------------------------------------------------------
  // Condition fields
  // ------------------------------------------------------------------

  // Returns {valid flag, condition} for a trap that carries a condition.
  function automatic logic [4:0] condFields(input tse_trap_t t, input logic [1:0] ctrl);
    logic [3:0] condition_code_field;
    condition_code_field = t.conditional ? t.instrCond : CONDITION_CODE_FIELD_ALWAYS;
    if (t.state64)
      condFields = {1'b1, CONDITION_CODE_FIELD_ALWAYS};                    // [RL11] [RL12]
    else if (!t.compact)
    begin
      // A known pass may be shown as unconditional when software asks.
      if (t.conditional && t.knownPass && ctrl[CTRL_PASS_AL])
        condFields = {1'b1, CONDITION_CODE_FIELD_ALWAYS};                  // [RL14]
      else
        condFields = {1'b1, condition_code_field};                         // [RL11] [RL13]
    end
    else if (ctrl[CTRL_CMP_CV])
      condFields = {1'b1, condition_code_field};                           // [RL15]
    else
      condFields = 5'h00;                                  // [RL15]
  endfunction

  // ------------------------------------------------------------------
  // Syndrome builder
  // ------------------------------------------------------------------

  // Builds the full syndrome; bad is set when the form needs a
  // reserved or barred mode code and the literal bit had to be dropped.
  function automatic logic [31:0] build(input tse_trap_t t, input logic [1:0] ctrl,
                                        input logic fpOk, input logic vecOk);
    logic [4:0]  cf;
    logic [2:0]  am;
    logic        bad;
    tse_synd_t   s;
    cf  = condFields(t, ctrl);
    am  = {t.literalForm, t.preIndex, t.writeback};      // [RL5] [RL6]
    bad = 1'b0;
    s   = '0;
    // Literal with writeback would be 101 or 111; stores take no literal,
    // compact loads take no literal unindexed form.
    if (t.literalForm && (t.writeback || !t.isLoad ||
        (t.compact && !t.preIndex)))
    begin
      am[2] = 1'b0;                                       // [RL3] [RL4]
      bad   = 1'b1;
    end
    unique case (t.kind)
      TK_COPROC_LS:
      begin
        s.excClass                = EC_COPROC_LS;         // [RL8]
        s.payload[POS_CV]         = cf[4];
        s.payload[POS_CONDITION_CODE_FIELD +: 4]  = cf[3:0];
        s.payload[POS_IMM8 +: 8]  = t.imm8;
        s.payload[POS_OFFSET]     = t.offsetAdd;          // [RL1]
        s.payload[POS_AM +: 3]    = am;                   // [RL2]
        s.payload[POS_DIR]        = t.isLoad;             // [RL7]
        // Register number stays zero: only defined for immediate form. [RL22]
      end
      TK_FP_SIMD:
      begin
        // One class covers FP, SIMD, vector and matrix accesses.
        if (fpOk || vecOk)                                // [RL9]
        begin
          s.excClass               = EC_FP_SIMD;          // [RL16]
          s.payload[POS_CV]        = cf[4];               // [RL11]
          s.payload[POS_CONDITION_CODE_FIELD +: 4] = cf[3:0];
        end
        else
          s.excClass = EC_UNKNOWN;                        // [RL10]
      end
      TK_VECTOR:
        s.excClass = vecOk ? EC_VECTOR : EC_UNKNOWN;      // [RL19] [RL18] [RL17]
      TK_ILLEGAL:
        s.excClass = EC_ILLEGAL;                          // [RL20]
      TK_PC_ALIGN:
        s.excClass = EC_PC_ALIGN;                         // [RL20]
      TK_SP_ALIGN:
        s.excClass = EC_SP_ALIGN;                         // [RL20]
      default:
        s.excClass = EC_UNKNOWN;
    endcase
    build = {bad, s};
  endfunction

  // ------------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------------

  // Unmapped offsets read zero with an error response.
  function automatic logic [33:0] readReg(input logic [7:0] a, input tse_state_t s);
    logic [31:0] d;
    logic [1:0]  r;
    d = '0;
    r = RESP_OKAY;
    unique case (a)
      REG_SYND:
      begin
        d[POS_CLASS +: 6] = s.synd.excClass;
        d[24:0]           = s.synd.payload;
      end
      REG_CTRL:
        d[1:0] = s.ctrl;
      REG_STAT:
      begin
        d[STAT_CAPT]       = s.captured;
        d[STAT_BADFORM]    = s.badForm;
        d[POS_COUNT +: 8]  = s.count;
      end
      default:
        r = RESP_SLVERR;
    endcase
    readReg = {r, d};
  endfunction

  // ------------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------------

  // Bus writes are applied before the trap so that a trap arriving with
  // a clear of its status flag still leaves the flag set.
  always_comb
  begin
    logic [31:0] b;
    logic [33:0] rd;
    b          = '0;
    rd         = '0;
    next_st    = st;
    next_st.syndValid = 1'b0;

    // Write address and data are taken independently.
    if (awvalid && st.awReady)
    begin
      next_st.awHeld = 1'b1;
      next_st.awAddr = awaddr;
    end
    if (wvalid && st.wReady)
    begin
      next_st.wHeld = 1'b1;
      next_st.wData = wdata;
      next_st.wStrb = wstrb;
    end
    if (st.bValid && bready)
      next_st.bValid = 1'b0;

    // Both halves held: perform the write and answer.
    if (st.awHeld && st.wHeld && !st.bValid)
    begin
      next_st.awHeld = 1'b0;
      next_st.wHeld  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = RESP_OKAY;
      unique case (st.awAddr)
        REG_SYND:
          next_st.bResp = RESP_OKAY;
        REG_CTRL:
          if (st.wStrb[0])
            next_st.ctrl = st.wData[1:0];
        REG_STAT:
          if (st.wStrb[0] && st.wData[STAT_BADFORM])
            next_st.badForm = 1'b0;
        default:
          next_st.bResp = RESP_SLVERR;
      endcase
    end

    // Read channel: data one cycle after the address is taken.
    if (st.rValid && rready)
      next_st.rValid = 1'b0;
    if (arvalid && st.arReady)
    begin
      rd             = readReg(araddr, st);
      next_st.rValid = 1'b1;
      next_st.rData  = rd[31:0];
      next_st.rResp  = rd[33:32];
    end

    // Capture at entry; held until the next trap.
    if (trap.valid)
    begin
      b                 = build(trap, st.ctrl, fpPresent, vecPresent);
      next_st.synd      = b[30:0];                         // [RL23]
      next_st.syndValid = 1'b1;
      next_st.captured  = 1'b1;
      next_st.count     = st.count + 8'h01;
      if (b[31])
        next_st.badForm = 1'b1;                            // [RL4]
    end

    next_st.awReady = !next_st.awHeld && !next_st.bValid;
    next_st.wReady  = !next_st.wHeld && !next_st.bValid;
    next_st.arReady = !next_st.rValid;
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------

  // Syndrome is cleared on reset although any value would do; a
  // defined value keeps simulation free of unknowns.
  always_ff @(posedge mclk)
  begin
    if (rst)
    begin
      st      <= '0;                                       // [RL21]
      st.ctrl <= CTRL_RESET;
    end
    else
      st <= next_st;
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------

  // Every output is a state field.
  assign synd      = st.synd;
  assign syndValid = st.syndValid;
  assign awready   = st.awReady;
  assign wready    = st.wReady;
  assign bvalid    = st.bValid;
  assign bresp     = st.bResp;
  assign arready   = st.arReady;
  assign rvalid    = st.rValid;
  assign rdata     = st.rData;
  assign rresp     = st.rResp;

endmodule

// File: verif/tse_encoder_sva.sv
// Purpose: Port-level checks on the trap syndrome encoder.
// Assumes: One mclk domain, rst synchronous and active high.
// Notes:   Bound to the encoder at the foot of this file.
`timescale 1ns/100ps

module tse_encoder_sva
  import tse_pkg::*;
(
  input wire logic               mclk,
  input wire logic               rst,
  input wire tse_pkg::tse_trap_t trap,
  input wire logic               fpPresent,
  input wire logic               vecPresent,
  input wire tse_pkg::tse_synd_t synd,
  input wire logic               syndValid
);
  // ----------------------------------------
  // Trap capture checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  // Load/store and FP trap kinds taken at an edge; the syndrome lands one edge later.
  sequence seqLs;
    trap.valid && trap.kind == TK_COPROC_LS;
  endsequence
  sequence seqFp;
    trap.valid && trap.kind == TK_FP_SIMD;
  endsequence

  chk_pulse_after: assert property (trap.valid |=> syndValid)
    else $error("syndrome valid missing after trap");
  chk_synd_held: assert property (!trap.valid |=> !syndValid && $stable(synd))
    else $error("syndrome changed without trap");
  chk_ls_class: assert property (seqLs |=> synd.excClass == 6'h06)
    else $error("load/store class wrong");
  chk_ls_bits: assert property (seqLs |=> synd.payload[4] == $past(trap.offsetAdd) &&
    synd.payload[0] == $past(trap.isLoad) &&
    synd.payload[2:1] == {$past(trap.preIndex), $past(trap.writeback)})
    else $error("load/store fields wrong");
  // A store never shows a literal mode, and writeback never pairs with it.
  chk_mode_legal: assert property (seqLs |=>
    !(synd.payload[3] && (synd.payload[1] || !synd.payload[0] ||
    ($past(trap.compact) && !synd.payload[2]))))
    else $error("reserved mode reported");
  chk_fp_class: assert property (seqFp ##0 (fpPresent || vecPresent) |=>
    synd.excClass == 6'h07 && synd.payload[19:0] == 20'h0_0000)
    else $error("fp class or low bits wrong");
  chk_fp_absent: assert property (seqFp ##0 !(fpPresent || vecPresent) |=>
    synd.excClass == 6'h00)
    else $error("fp class without support wrong");
  chk_wide_condition_code_field: assert property (seqFp ##0 trap.state64 ##0 (fpPresent || vecPresent)
    |=> synd.payload[24:20] == 5'h1e)
    else $error("64-bit condition wrong");
  chk_vec_synd: assert property (trap.valid && trap.kind == TK_VECTOR |=>
    synd.payload == 25'h000_0000 &&
    synd.excClass == ($past(vecPresent) ? 6'h19 : 6'h00))
    else $error("vector syndrome wrong");
  chk_fault_zero: assert property (trap.valid && trap.kind inside
    {TK_ILLEGAL, TK_PC_ALIGN, TK_SP_ALIGN} |=> synd.payload == 25'h000_0000)
    else $error("fault payload not zero");
endmodule

bind tse_trap_syndrome_encoder tse_encoder_sva uSva (.mclk(mclk), .rst(rst), .trap(trap),
  .fpPresent(fpPresent), .vecPresent(vecPresent), .synd(synd), .syndValid(syndValid));

// File: verif/tb_trap_syndrome_encoder.sv
// Purpose: Random trap traffic and register accesses against a bench model.
// Assumes: Register map and mode choices as the designer settled them.
// Notes:   Illegal load/store forms are driven on purpose.
`timescale 1ns/100ps

module tb_trap_syndrome_encoder
  import tse_pkg::*;
;
  logic        mclk = 1'b0, rst = 1'b1, fpPresent = 1'b1, vecPresent = 1'b1;
  tse_trap_t   trap = '0;
  tse_synd_t   synd, exp = '0;
  logic        syndValid, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata;
  logic [3:0]  wstrb = 4'hf;
  logic [1:0]  bresp, rresp, ctrl = 2'h1;
  logic        bad = 1'b0;
  int          cnt = 0, errorCnt = 0, samplesChecked = 0;

  // ----------------------------------------
  // Clock, design and helpers
  // ----------------------------------------
  always #12.5 mclk = ~mclk;

  tse_trap_syndrome_encoder dut (.mclk(mclk), .rst(rst), .trap(trap), .fpPresent(fpPresent),
    .vecPresent(vecPresent), .synd(synd), .syndValid(syndValid), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready));

  task automatic end_sim;
    $display("Checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp_word(string nm, logic [31:0] e, logic [31:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errorCnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic cmp_synd(tse_synd_t e, tse_synd_t g);
    samplesChecked++;
    if (g !== e)
    begin
      errorCnt++;
      $display("CHECK FAILED synd expected %h seen %h", e, g);
    end
  endtask

  // A bus wait that runs out ends the run as a mismatch.
  task automatic give_up(logic done);
    if (!done)
    begin
      errorCnt++;
      end_sim();
    end
  endtask

  // Address and data are offered together and each is released when taken.
  task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 40)
    begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid)
      begin
        r = bresp;
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    give_up(done);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic done;
    n = 0;
    done = 1'b0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 40)
    begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid)
      begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    give_up(done);
  endtask

  // Bench model of one captured trap; it also tracks the count and bad-form flag.
  function automatic tse_synd_t model(tse_trap_t t, logic fp, logic vec);
    tse_synd_t s;
    logic cv, lit;
    logic [3:0] cd;
    s = '0;
    cv = 1'b1;
    cd = 4'he;
    if (!t.state64 && t.conditional && !(t.knownPass && ctrl[1] && !t.compact))
      cd = t.instrCond;
    if (!t.state64 && t.compact && !ctrl[0])
    begin
      cv = 1'b0;
      cd = 4'h0;
    end
    cnt++;
    lit = t.literalForm && t.isLoad && !t.writeback && !(t.compact && !t.preIndex);
    // The flag follows the form fields of every captured trap, whatever its kind.
    bad |= t.literalForm && !lit;
    case (t.kind)
      TK_COPROC_LS:
      begin
        s = {6'h06, cv, cd, t.imm8, 7'h00, t.offsetAdd, lit, t.preIndex, t.writeback,
          t.isLoad};
      end
      TK_FP_SIMD: if (fp || vec) s = {6'h07, cv, cd, 20'h0_0000};
      TK_VECTOR: if (vec) s.excClass = 6'h19;
      TK_ILLEGAL: s.excClass = EC_ILLEGAL;
      TK_PC_ALIGN: s.excClass = EC_PC_ALIGN;
      TK_SP_ALIGN: s.excClass = EC_SP_ALIGN;
      default: s = '0;
    endcase
    return s;
  endfunction

  // Random traps, often back to back; each result is checked one edge later.
  task automatic run_traps(int n);
    tse_trap_t t, p;
    logic [31:0] r;
    logic pf, pv;
    p = '0;
    for (int i = 0; i <= n; i++)
    begin
      r = $urandom;
      t = r[24:0];
      t.kind = tse_kind_t'($urandom_range(5));
      if (t.state64) t.compact = 1'b0;
      if (i == n) t.valid = 1'b0;
      @(posedge mclk);
      trap <= t;
      fpPresent <= r[25];
      vecPresent <= r[26];
      @(negedge mclk);
      if (p.valid) exp = model(p, pf, pv);
      cmp_synd(exp, synd);
      cmp_word("valid", {31'h0, p.valid}, {31'h0, syndValid});
      p = t;
      pf = r[25];
      pv = r[26];
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    logic [1:0] rs;
    logic [31:0] d;
    void'($urandom(77));
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(REG_CTRL, d, rs);
    cmp_word("ctrl", 32'h0000_0001, d);
    rd(8'h0c, d, rs);
    cmp_word("unmapped", {30'h0, RESP_SLVERR}, {30'h0, rs});
    // Every mode setting sees its own batch of traps.
    for (int c = 0; c < 4; c++)
    begin
      wr(REG_CTRL, c, rs);
      ctrl = c[1:0];
      run_traps(60);
      rd(REG_SYND, d, rs);
      cmp_word("synd reg", {exp.excClass, 1'b0, exp.payload}, d);
      rd(REG_STAT, d, rs);
      cmp_word("stat", {16'h0, cnt[7:0], 6'h0, bad, 1'b1}, d);
    end
    // The bad-form flag clears on a one written to it; a syndrome write is ignored.
    wr(REG_STAT, 32'h0000_0002, rs);
    bad = 1'b0;
    wr(REG_SYND, 32'hffff_ffff, rs);
    cmp_word("synd wr resp", {30'h0, RESP_OKAY}, {30'h0, rs});
    rd(REG_STAT, d, rs);
    cmp_word("stat clr", {16'h0, cnt[7:0], 6'h0, bad, 1'b1}, d);
    end_sim();
  end
endmodule
